/* File: core/pfs_defines.svh */
// How it works
// - pulse rate becomes a 10-bit proportional value
// - input is always active low, polarity ignored
// - measures pulse rates from 10 Hz to 20 kHz
// - read-only input rate in hertz, 0..65535, saturating
// - read-only signed input percent after offset, gain
// - enabled: pin function ignored, status bit1 zero
// - disabled: input idle, both readbacks held zero
// - normalise, clamp, scale, add offset, apply gain
// - gain accepted 0.000..9.999, default 1.000
// - band limits 10..20000 Hz, defaults 10/10000
// - negative result keeps its sign downstream
// - result filtered with shared filter time constant
// - pulse output only on second transistor pin
// - read-only output percent 0.0..100.0 of range
// - read-only generated output rate in hertz
// - select 15 keeps pin as ordinary output
// - output limits 10..20000 Hz, defaults 10/10000
`ifndef PFS_DEFINES_SVH
`define PFS_DEFINES_SVH
`define PFS_CLK_HZ 200000000
`define PFS_GATE_MS 1000
`define PFS_HZ_LO 16'h000A
`define PFS_HZ_HI 16'h4E20
`define PFS_HZ_MAX_DEF 16'h2710
`define PFS_GAIN_MAX 16'h270F
`define PFS_GAIN_DEF 16'h03E8
`define PFS_GAIN_UNIT 27'sh00003E8
`define PFS_PCT_FULL 16'h03E8
`define PFS_PCT_POS 16'sh03E8
`define PFS_PCT_NEG -16'sh03E8
`define PFS_NORM_FULL 10'h3FF
`define PFS_FO_OFF 5'h0F
`define PFS_DI2_BIT 1
`define PFS_EDGE_SAT 16'hFFFF
`endif

/* File: core/pfs_pkg.sv */
package pfs_pkg;
  // input scaler settings, values in Hz, 0.001 gain and 0.1 percent
  typedef struct packed {
    logic [15:0] enable;
    logic [15:0] gain;
    logic [15:0] minHz;
    logic [15:0] offset;
    logic [15:0] maxHz;
  } pfs_in_cfg_t;
  // output generator settings
  typedef struct packed {
    logic [4:0] funcSel;
    logic [15:0] minHz;
    logic [15:0] maxHz;
  } pfs_out_cfg_t;
  typedef enum logic [2:0] {
    MEAS_OFF = 3'b001,
    MEAS_COUNT = 3'b010,
    MEAS_LATCH = 3'b100
  } pfs_meas_t;
endpackage

/* File: core/pfs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module pfs_sync #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic asyncIn,
  output logic syncOut
);
  logic stage1_ff;
  logic stage2_ff;
  // two-stage synchroniser, first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      stage1_ff <= RESET_VAL;
      stage2_ff <= RESET_VAL;
    end else if (clkEnable) begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end
  assign syncOut = stage2_ff;
endmodule
`default_nettype wire

/* File: core/pfs_pulse_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module pfs_pulse_gen #(
  parameter int PW = 24
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic run,
  input wire logic [PW-1:0] halfPeriod,
  output logic pulseOut
);
  logic [PW-1:0] cnt_ff;
  logic level_ff;
  if (PW < 2) begin : g_chk
    $error("pfs_pulse_gen: PW too small");
  end
  // half-period divider, square wave toggles at each wrap
  always_ff @(posedge clk) begin
    if (!reset_n || !run) begin
      cnt_ff <= '0;
      level_ff <= 1'b0;
    end else if (clkEnable) begin
      if (cnt_ff + 1'b1 >= halfPeriod) begin
        cnt_ff <= '0;
        level_ff <= ~level_ff;
      end else begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end
  assign pulseOut = level_ff;
endmodule
`default_nettype wire

/* File: core/pfs_scaler.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defines.svh"
module pfs_scaler #(
  parameter int GATE_CYCLES = (`PFS_CLK_HZ / 1000) * `PFS_GATE_MS,
  parameter int HALF_W = 24
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clkEnable,
  input wire logic pulseRateInputPin,
  input wire pfs_pkg::pfs_in_cfg_t inCfg,
  input wire logic [2:0] sharedFilterTimeConstant,
  input wire logic [7:0] digitalInputStatusRaw,
  input wire pfs_pkg::pfs_out_cfg_t outCfg,
  input wire logic [15:0] outSourcePercent,
  input wire logic digitalOutValue,
  output logic [15:0] inFreqHertz,
  output logic [15:0] inFreqPercent,
  output logic [9:0] inFreqNormalised,
  output logic [7:0] digitalInputStatusWord,
  output logic secondInputFunctionActive,
  output logic secondTransistorOutputPin,
  output logic [15:0] outFreqPercent,
  output logic [15:0] outFreqHertz
);
  import pfs_pkg::*;

  localparam int GW = $clog2(GATE_CYCLES + 1);
  localparam logic [GW-1:0] GATE_LAST = GW'(GATE_CYCLES - 1);
  localparam logic [31:0] HALF_CLK = 32'(`PFS_CLK_HZ / 2);

  // refuse settings the counters cannot hold
  if (GATE_CYCLES < 2) begin : g_chk_gate
    $error("pfs_scaler: GATE_CYCLES must be at least 2");
  end
  if (HALF_W < 24 || HALF_W > 31) begin : g_chk_half
    $error("pfs_scaler: HALF_W must lie in 24..31");
  end

  pfs_meas_t state_ff;
  pfs_meas_t nxt_state;
  logic pinSync;
  logic pinPrev_ff;
  logic edgeSeen;
  logic enabled;
  logic [GW-1:0] gate_ff;
  logic gateEnd;
  logic [15:0] edgeCnt_ff;
  logic [15:0] hzRaw_ff;
  logic [15:0] inHz_ff;
  logic signed [15:0] filt_ff;
  logic [9:0] norm_ff;
  logic [7:0] diStatus_ff;
  logic funcActive_ff;

  // clamped input settings
  logic [15:0] gainC;
  logic [15:0] minC;
  logic [15:0] maxC;
  logic signed [15:0] offC;
  // scaler arithmetic
  logic signed [16:0] num;
  logic signed [16:0] span;
  logic [9:0] normVal;
  logic [15:0] pctNorm;
  logic signed [16:0] pctSum;
  logic signed [26:0] pctProd;
  logic signed [26:0] pctScaled;
  logic signed [15:0] pctTarget;
  logic signed [16:0] filtDiff;
  logic signed [16:0] filtStep;

  // output generator signals
  logic [15:0] outMinC;
  logic [15:0] outMaxC;
  logic [15:0] outSpan;
  logic [15:0] outPctC;
  logic [15:0] outHzVal;
  logic outActive;
  logic [HALF_W-1:0] halfVal;
  logic [HALF_W-1:0] half_ff;
  logic outRun_ff;
  logic pulseLevel;
  logic [15:0] outPct_ff;
  logic [15:0] outHz_ff;
  logic do2_ff;

  assign enabled = inCfg.enable[0];

  // input pin is synchronised before anything looks at it
  pfs_sync #(
    .RESET_VAL(1'b1)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .asyncIn(pulseRateInputPin),
    .syncOut(pinSync)
  );

  // previous synchronised level for edge detection
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pinPrev_ff <= 1'b1;
    end else if (clkEnable) begin
      pinPrev_ff <= pinSync;
    end
  end

  // active edge is high-to-low, whatever the general polarity
  assign edgeSeen = pinPrev_ff & ~pinSync;

  // measurement sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      MEAS_OFF: begin
        if (enabled) begin
          nxt_state = MEAS_COUNT;
        end
      end
      MEAS_COUNT: begin
        if (!enabled) begin
          nxt_state = MEAS_OFF;
        end else if (gateEnd) begin
          nxt_state = MEAS_LATCH;
        end
      end
      MEAS_LATCH: begin
        nxt_state = enabled ? MEAS_COUNT : MEAS_OFF;
      end
      default: begin
        nxt_state = MEAS_OFF;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= MEAS_OFF;
    end else if (clkEnable) begin
      state_ff <= nxt_state;
    end
  end

  // fixed gate timer, runs while the input is enabled
  assign gateEnd = (gate_ff == GATE_LAST);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      gate_ff <= '0;
    end else if (clkEnable) begin
      if (!enabled || state_ff == MEAS_OFF) begin
        gate_ff <= '0;
      end else if (gateEnd) begin
        gate_ff <= '0;
      end else begin
        gate_ff <= gate_ff + 1'b1;
      end
    end
  end

  // edge counter, saturates; an edge at the gate end opens the next gate
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      edgeCnt_ff <= '0;
      hzRaw_ff <= '0;
    end else if (clkEnable) begin
      if (!enabled || state_ff == MEAS_OFF) begin
        edgeCnt_ff <= '0;
        hzRaw_ff <= '0;
      end else if (gateEnd) begin
        hzRaw_ff <= edgeCnt_ff;
        edgeCnt_ff <= {15'h0000, edgeSeen};
      end else if (edgeSeen && edgeCnt_ff != `PFS_EDGE_SAT) begin
        edgeCnt_ff <= edgeCnt_ff + 1'b1;
      end
    end
  end

  // settings held inside their accepted ranges
  always_comb begin
    gainC = (inCfg.gain > `PFS_GAIN_MAX) ? `PFS_GAIN_MAX : inCfg.gain;
    minC = inCfg.minHz;
    if (minC < `PFS_HZ_LO) begin
      minC = `PFS_HZ_LO;
    end else if (minC > `PFS_HZ_HI) begin
      minC = `PFS_HZ_HI;
    end
    maxC = inCfg.maxHz;
    if (maxC < `PFS_HZ_LO) begin
      maxC = `PFS_HZ_LO;
    end else if (maxC > `PFS_HZ_HI) begin
      maxC = `PFS_HZ_HI;
    end
    offC = $signed(inCfg.offset);
    if (offC > `PFS_PCT_POS) begin
      offC = `PFS_PCT_POS;
    end else if (offC < `PFS_PCT_NEG) begin
      offC = `PFS_PCT_NEG;
    end
  end

  // band normalisation to ten bits, clamped to 0..1
  always_comb begin
    num = $signed({1'b0, hzRaw_ff}) - $signed({1'b0, minC});
    span = $signed({1'b0, maxC}) - $signed({1'b0, minC});
    if (num <= 17'sh00000) begin
      normVal = 10'h000;
    end else if (num >= span) begin
      normVal = `PFS_NORM_FULL;
    end else begin
      normVal = 10'((32'(num) * 32'(`PFS_NORM_FULL)) / 32'(span));
    end
  end

  // percent of full scale, offset added, then gain applied
  always_comb begin
    pctNorm = 16'((32'(normVal) * 32'(`PFS_PCT_FULL)) / 32'(`PFS_NORM_FULL));
    pctSum = $signed({1'b0, pctNorm}) + 17'(offC);
    pctProd = 27'(pctSum) * $signed({11'h000, gainC});
    pctScaled = pctProd / `PFS_GAIN_UNIT;
    if (pctScaled > 27'(`PFS_PCT_POS)) begin
      pctTarget = `PFS_PCT_POS;
    end else if (pctScaled < 27'(`PFS_PCT_NEG)) begin
      pctTarget = `PFS_PCT_NEG;
    end else begin
      pctTarget = 16'(pctScaled);
    end
  end

  // first-order filter step, time constant shared with analog input
  always_comb begin
    filtDiff = 17'(pctTarget) - 17'(filt_ff);
    filtStep = filtDiff >>> sharedFilterTimeConstant;
  end

  // readbacks refresh once per gate, cleared while disabled
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      inHz_ff <= '0;
      filt_ff <= '0;
      norm_ff <= '0;
    end else if (clkEnable) begin
      if (!enabled) begin
        inHz_ff <= '0;
        filt_ff <= '0;
        norm_ff <= '0;
      end else if (state_ff == MEAS_LATCH) begin
        inHz_ff <= hzRaw_ff;
        filt_ff <= 16'(17'(filt_ff) + filtStep);
        norm_ff <= normVal;
      end
    end
  end

  // pin takeover: status bit forced low, ordinary function released
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      diStatus_ff <= '0;
      funcActive_ff <= 1'b1;
    end else if (clkEnable) begin
      diStatus_ff <= digitalInputStatusRaw;
      if (enabled) begin
        diStatus_ff[`PFS_DI2_BIT] <= 1'b0;
      end
      funcActive_ff <= ~enabled;
    end
  end

  // output settings and source percent held in range
  always_comb begin
    outMinC = outCfg.minHz;
    if (outMinC < `PFS_HZ_LO) begin
      outMinC = `PFS_HZ_LO;
    end else if (outMinC > `PFS_HZ_HI) begin
      outMinC = `PFS_HZ_HI;
    end
    outMaxC = outCfg.maxHz;
    if (outMaxC < `PFS_HZ_LO) begin
      outMaxC = `PFS_HZ_LO;
    end else if (outMaxC > `PFS_HZ_HI) begin
      outMaxC = `PFS_HZ_HI;
    end
    outSpan = (outMaxC > outMinC) ? (outMaxC - outMinC) : 16'h0000;
    if ($signed(outSourcePercent) < 16'sh0000) begin
      outPctC = 16'h0000;
    end else if (outSourcePercent > `PFS_PCT_FULL) begin
      outPctC = `PFS_PCT_FULL;
    end else begin
      outPctC = outSourcePercent;
    end
  end

  // generated rate and half period of the square wave
  always_comb begin
    outActive = (outCfg.funcSel != `PFS_FO_OFF);
    outHzVal = outMinC + 16'((32'(outPctC) * 32'(outSpan)) / 32'(`PFS_PCT_FULL));
    halfVal = HALF_W'(HALF_CLK / 32'(outHzVal));
  end

  // registered generator settings and readbacks
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      half_ff <= '1;
      outRun_ff <= 1'b0;
      outPct_ff <= '0;
      outHz_ff <= '0;
    end else if (clkEnable) begin
      half_ff <= halfVal;
      outRun_ff <= outActive;
      outPct_ff <= outActive ? outPctC : 16'h0000;
      outHz_ff <= outActive ? outHzVal : 16'h0000;
    end
  end

  pfs_pulse_gen #(
    .PW(HALF_W)
  ) u_gen (
    .clk(clk),
    .reset_n(reset_n),
    .clkEnable(clkEnable),
    .run(outRun_ff),
    .halfPeriod(half_ff),
    .pulseOut(pulseLevel)
  );

  // the second transistor pin is the only pulse output
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      do2_ff <= 1'b0;
    end else if (clkEnable) begin
      do2_ff <= outRun_ff ? pulseLevel : digitalOutValue;
    end
  end

  // outputs straight from flip-flops
  assign inFreqHertz = inHz_ff;
  assign inFreqPercent = filt_ff;
  assign inFreqNormalised = norm_ff;
  assign digitalInputStatusWord = diStatus_ff;
  assign secondInputFunctionActive = funcActive_ff;
  assign secondTransistorOutputPin = do2_ff;
  assign outFreqPercent = outPct_ff;
  assign outFreqHertz = outHz_ff;
endmodule
`default_nettype wire

/* File: tb/pfs_scaler_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pfs_scaler_properties #(
  parameter int GATE_CYCLES = 1000
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire pfs_pkg::pfs_in_cfg_t inCfg,
  input wire logic [7:0] digitalInputStatusRaw,
  input wire pfs_pkg::pfs_out_cfg_t outCfg,
  input wire logic digitalOutValue,
  input wire logic [15:0] inFreqHertz,
  input wire logic [15:0] inFreqPercent,
  input wire logic [7:0] digitalInputStatusWord,
  input wire logic secondInputFunctionActive,
  input wire logic secondTransistorOutputPin,
  input wire logic [15:0] outFreqPercent,
  input wire logic [15:0] outFreqHertz
);
  import pfs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // status word follows raw inputs, bit1 held low while enabled
  property p_stat_mask;
    inCfg.enable[0] |=> digitalInputStatusWord == ($past(digitalInputStatusRaw) & 8'hFD);
  endproperty
  a_stat_mask: assert property (p_stat_mask) else $error("status bit1 not masked");
  property p_stat_pass;
    !inCfg.enable[0] |=> digitalInputStatusWord == $past(digitalInputStatusRaw);
  endproperty
  a_stat_pass: assert property (p_stat_pass) else $error("status word wrong");
  property p_func_act;
    1'b1 |=> secondInputFunctionActive == !$past(inCfg.enable[0]);
  endproperty
  a_func_act: assert property (p_func_act) else $error("pin function not released");
  property p_off_zero;
    !inCfg.enable[0] |=> inFreqHertz == 16'h0000 && inFreqPercent == 16'h0000;
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("readbacks not zero");
  property p_pct_rng;
    $signed(inFreqPercent) >= -16'sh03E8 && $signed(inFreqPercent) <= 16'sh03E8;
  endproperty
  a_pct_rng: assert property (p_pct_rng) else $error("input percent out of range");
  property p_hz_rng;
    inFreqHertz <= 16'h4E20;
  endproperty
  a_hz_rng: assert property (p_hz_rng) else $error("input hertz out of range");
  // disabled output: readbacks zero, pin shows ordinary level
  property p_out_off;
    outCfg.funcSel == 5'h0F |=> outFreqHertz == 16'h0000 && outFreqPercent == 16'h0000;
  endproperty
  a_out_off: assert property (p_out_off) else $error("output readbacks not zero");
  property p_pin_dig;
    outCfg.funcSel == 5'h0F ##1 outCfg.funcSel == 5'h0F
      |=> secondTransistorOutputPin == $past(digitalOutValue);
  endproperty
  a_pin_dig: assert property (p_pin_dig) else $error("pin not ordinary output");
  property p_out_rng;
    outCfg.funcSel != 5'h0F |=> outFreqPercent <= 16'h03E8 && outFreqHertz >= 16'h000A
      && outFreqHertz <= 16'h4E20;
  endproperty
  a_out_rng: assert property (p_out_rng) else $error("output readback out of range");
endmodule
bind pfs_scaler pfs_scaler_properties #(.GATE_CYCLES(GATE_CYCLES)) i_props (
  .clk(clk),
  .reset_n(reset_n),
  .inCfg(inCfg),
  .digitalInputStatusRaw(digitalInputStatusRaw),
  .outCfg(outCfg),
  .digitalOutValue(digitalOutValue),
  .inFreqHertz(inFreqHertz),
  .inFreqPercent(inFreqPercent),
  .digitalInputStatusWord(digitalInputStatusWord),
  .secondInputFunctionActive(secondInputFunctionActive),
  .secondTransistorOutputPin(secondTransistorOutputPin),
  .outFreqPercent(outFreqPercent),
  .outFreqHertz(outFreqHertz)
);
`default_nettype wire

/* File: tb/pfs_pulse_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pfs_pulse_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [15:0] srcPeriod,
  input wire logic outPin,
  output logic srcPin,
  output logic [31:0] highLen
);
  logic [15:0] phase = 16'h0000;
  logic [31:0] run = 32'h0000_0000;
  // source idles high, pulses pull low; periods under 8 cycles never sent
  always @(posedge clk) begin
    if (!reset_n || srcPeriod < 16'h0008) begin
      phase <= 16'h0000;
      srcPin <= 1'b1;
    end else begin
      phase <= (phase + 16'h0001 >= srcPeriod) ? 16'h0000 : phase + 16'h0001;
      srcPin <= (phase >= (srcPeriod >> 1));
    end
  end
  // consumer: length of the last complete high run on the output pin
  always @(posedge clk) begin
    if (!reset_n) begin
      run <= 32'h0000_0000;
      highLen <= 32'h0000_0000;
    end else begin
      run <= outPin ? run + 32'h0000_0001 : 32'h0000_0000;
      if (!outPin && run != 32'h0000_0000) begin
        highLen <= run;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/pfs_scaler_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pfs_scaler_tb;
  import pfs_pkg::*;
  typedef struct {string name; int sel; int expV; int tol;} pfs_note_t;
  localparam int GATE = 1000;
  localparam int T_MIN [7] = '{10, 10, 10, 150, 150, 10, 10};
  localparam int T_MAX [7] = '{50, 50, 50, 200, 200, 50, 20000};
  localparam int T_OFF [7] = '{-700, 0, -700, -300, -300, -900, 0};
  localparam int T_GAIN [7] = '{1000, 2000, 2000, 1000, 0, 9999, 1000};
  localparam int T_PCT [7] = '{300, 1000, 600, -300, 0, 999, 3};
  localparam int T_NRM [7] = '{1023, 1023, 1023, 0, 0, 1023, 4};
  logic clk, reset_n, dov, srcPin, outPin;
  pfs_in_cfg_t inCfg;
  pfs_out_cfg_t outCfg;
  logic [7:0] statRaw;
  logic [2:0] filtShift;
  logic [9:0] inNorm;
  logic [15:0] outSrc, inHz, inPct, outPct, outHz, srcPeriod;
  logic [31:0] highLen, rnd;
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  pfs_note_t notes[$];
  event sampleEv;
  pfs_scaler #(.GATE_CYCLES(GATE)) i_dut (.clk(clk), .reset_n(reset_n), .clkEnable(1'b1),
    .pulseRateInputPin(srcPin), .inCfg(inCfg), .sharedFilterTimeConstant(filtShift),
    .digitalInputStatusRaw(statRaw), .outCfg(outCfg), .outSourcePercent(outSrc),
    .digitalOutValue(dov), .inFreqHertz(inHz), .inFreqPercent(inPct),
    .inFreqNormalised(inNorm), .digitalInputStatusWord(), .secondInputFunctionActive(),
    .secondTransistorOutputPin(outPin), .outFreqPercent(outPct), .outFreqHertz(outHz));
  pfs_pulse_model i_far (.clk(clk), .reset_n(reset_n), .srcPeriod(srcPeriod),
    .outPin(outPin), .srcPin(srcPin), .highLen(highLen));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp_val(input string name, input int expV, input logic [31:0] got,
                         input int tol);
    n_compared++;
    if ($isunknown(got) || $signed(got) > expV + tol || $signed(got) < expV - tol) begin
      err_count++;
      $display("[ERR] %s expected %0d seen %0d", name, expV, $signed(got));
    end
  endtask
  task automatic note(input string name, input int sel, input int expV, input int tol);
    notes.push_back('{name, sel, expV, tol});
    -> sampleEv;
    #1;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  // random status bits and ordinary output level, plus hang watch
  always @(posedge clk) begin
    rnd <= lfsr_next(rnd);
    statRaw <= rnd[7:0];
    dov <= rnd[8];
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      end_of_test();
    end
  end
  // oldest note against the output it names
  always @(sampleEv) begin
    pfs_note_t n;
    logic [31:0] got;
    n = notes.pop_front();
    case (n.sel)
      0: got = {16'h0000, inHz};
      1: got = {{16{inPct[15]}}, inPct};
      2: got = {22'h000000, inNorm};
      3: got = {16'h0000, outHz};
      4: got = {16'h0000, outPct};
      default: got = highLen;
    endcase
    cmp_val(n.name, n.expV, got, n.tol);
  end
  initial begin
    reset_n = 1'b0;
    inCfg = '{16'h0001, 16'h03E8, 16'h000A, 16'h0000, 16'h2710};
    outCfg = '{5'h0F, 16'h000A, 16'h4E20};
    outSrc = 16'h01F4;
    statRaw = 8'h00;
    filtShift = 3'h0;
    dov = 1'b0;
    rnd = 32'h0000_93F3;
    srcPeriod = 16'h000A;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    // 100 pulses per gate against a table of band, offset and gain
    for (int i = 0; i < 7; i++) begin
      inCfg.minHz <= 16'(T_MIN[i]);
      inCfg.maxHz <= 16'(T_MAX[i]);
      inCfg.offset <= 16'(T_OFF[i]);
      inCfg.gain <= 16'(T_GAIN[i]);
      settle(3 * GATE);
      note("in hertz", 0, 100, 1);
      note("in percent", 1, T_PCT[i], 0);
      note("in normalised", 2, T_NRM[i], 0);
    end
    // shared filter at shift 1: half the distance to target per gate
    filtShift <= 3'h1;
    inCfg.offset <= 16'hFD44;
    settle(GATE);
    note("in percent filt1", 1, -347, 0);
    settle(GATE);
    note("in percent filt2", 1, -522, 0);
    inCfg.enable <= 16'h0000;
    settle(3);
    note("in hertz off", 0, 0, 0);
    note("in percent off", 1, 0, 0);
    // every output function code; only 15 leaves the pin alone
    for (int s = 0; s < 32; s++) begin
      outCfg.funcSel <= 5'(s);
      settle(3);
      note("out hertz", 3, (s == 15) ? 0 : 10005, 0);
    end
    note("out percent", 4, 500, 0);
    outSrc <= 16'h05DC;
    settle(3);
    note("out percent clamp", 4, 1000, 0);
    note("out hertz max", 3, 20000, 0);
    settle(25000);
    note("out half period", 5, 5000, 2);
    outSrc <= 16'hFF38;
    settle(3);
    note("out percent low", 4, 0, 0);
    note("out hertz min", 3, 10, 0);
    end_of_test();
  end
endmodule
`default_nettype wire
